// >>> mbcm_pkg.sv
// constants and carrier types of the command mailbox
package mbcm_pkg;
    localparam logic [15:0] FRAME_BASE = 16'h1f40;
    localparam logic [15:0] HANDLED_ADDR = 16'h1f54;
    localparam logic [15:0] STATUS_ADDR = 16'h1f55;
    localparam logic [15:0] DATA_LEN_ADDR = 16'h1f56;
    localparam int FRAME_WORDS = 20;
    localparam int W_CODE = 0;
    localparam int W_LEN = 1;
    localparam int W_DEST = 2;
    localparam int W_PWFLAG = 3;
    localparam int W_PW_HI = 4;
    localparam int W_PW_LO = 5;
    localparam int W_PARAM = 6;
    localparam int W_UNUSED_LO = 7;
    localparam int W_UNUSED_HI = 16;
    localparam int W_SETUP0 = 17;
    localparam int W_SETUP1 = 18;
    localparam int W_SETUP2 = 19;
    localparam int MINMAX_CLEAR_BIT = 9;
    localparam logic [15:0] CMD_RESET_MINMAX = 16'hb688;
    localparam logic [15:0] DEST_MINMAX = 16'h1401;
    localparam logic [15:0] PW_FLAG = 16'h0001;
    localparam logic [15:0] FIXED_LEN = 16'h000a;
    localparam logic [15:0] BYTES_PER_PARAM = 16'h0002;
    localparam logic [15:0] MINMAX_LEN = FIXED_LEN + BYTES_PER_PARAM;
    localparam logic [15:0] SETUP0 = 16'h1f53;
    localparam logic [15:0] SETUP1 = 16'h1f54;
    localparam logic [15:0] SETUP2 = 16'h1f55;
    localparam logic [15:0] STATUS_BUSY = 16'h0003;
    localparam logic [7:0] STATUS_DONE_HI = 8'h00;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_PASSWORD = 8'h01;
    localparam logic [7:0] ERR_ARG = 8'h0f;
    localparam logic [7:0] ERR_UNSUPPORTED = 8'h13;
    localparam logic [7:0] ERR_BUSY = 8'h9e;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [15:0] RST_CODE = 16'h0000;
    localparam logic [15:0] RST_DATA_LEN = 16'h0000;
    localparam logic [15:0] MINMAX_DATA_LEN = 16'h0000;
    localparam int EXEC_CYCLES_DEF = 16;

    typedef enum logic [2:0] {
        MBCM_IDLE = 3'b001,
        MBCM_CHECK = 3'b010,
        MBCM_EXEC = 3'b100
    } mbcm_fsm_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } mbcm_wr_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } mbcm_rd_t;

    typedef struct packed {
        mbcm_fsm_t fsm;
        logic [FRAME_WORDS-1:0][15:0] frame;
        logic [FRAME_WORDS-1:0] written;
        logic [15:0] cmd_code;
        logic refused;
        logic [15:0] refused_code;
        logic [7:0] err;
        logic [15:0] count;
        logic [15:0] handled;
        logic [15:0] status;
        logic [15:0] data_len;
        logic rd_valid;
        logic [15:0] rd_data;
        logic clear_pulse;
        logic busy;
    } mbcm_state_t;
endpackage : mbcm_pkg

// >>> mbcm_command_mailbox.sv
// command mailbox: frame capture, checking, execution and status registers
// Function
// - word0 is the command code; 46728 selects the min/max reset.
// - word1 is parameter length in bytes, 10 plus 2 per parameter.
// - word2 is the destination; min/max reset needs 0x1401.
// - words 4 and 5 hold a four-char password, first char upper byte.
// - word6 bit 9 requests clearing of stored energy min/max values.
// - words 17 to 19 must hold 8019, 8020 and 8021.
// - status register reads 0x0003 while a command executes.
// - handled command code is reported in register 8020.
// - status low byte holds the error code on completion, zero is success.
// - wrong password or rights gives error code 1.
// - unsupported command code completes with error 19.
// - a frame arriving during execution is refused with error 158.
// - after success, returned data length sits in register 8022.
`timescale 1ns/1ps

module mbcm_command_mailbox #(
    parameter int EXEC_CYCLES = mbcm_pkg::EXEC_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic srst,
    input wire mbcm_pkg::mbcm_wr_t wr_req,
    input wire mbcm_pkg::mbcm_rd_t rd_req,
    input wire logic [31:0] admin_password,
    input wire logic [31:0] operator_password,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic energy_minmax_clear,
    output logic busy
);

    mbcm_pkg::mbcm_state_t state_reg;
    mbcm_pkg::mbcm_state_t state_next;

    localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1);

    function automatic logic in_frame(input logic [15:0] addr);
        logic [15:0] top;
        top = mbcm_pkg::FRAME_BASE + 16'(mbcm_pkg::FRAME_WORDS);
        in_frame = (addr >= mbcm_pkg::FRAME_BASE) && (addr < top);
    endfunction : in_frame

    function automatic logic [4:0] frame_index(input logic [15:0] addr);
        logic [15:0] diff;
        diff = addr - mbcm_pkg::FRAME_BASE;
        frame_index = diff[4:0];
    endfunction : frame_index

    // one fault flag per frame word; code and password words are judged elsewhere, the parameter word is never judged
    logic [mbcm_pkg::FRAME_WORDS-1:0] word_bad;

    genvar g;
    generate
        for (g = 0; g < mbcm_pkg::FRAME_WORDS; g++) begin : g_word
            if (g == mbcm_pkg::W_LEN) begin : g_len
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::MINMAX_LEN;
            end else if (g == mbcm_pkg::W_DEST) begin : g_dest
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::DEST_MINMAX;
            end else if (g == mbcm_pkg::W_PWFLAG) begin : g_pwflag
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::PW_FLAG;
            end else if ((g >= mbcm_pkg::W_UNUSED_LO) && (g <= mbcm_pkg::W_UNUSED_HI)) begin : g_unused
                // unused parameter words must be zero
                assign word_bad[g] = |state_reg.frame[g];
            end else if (g == mbcm_pkg::W_SETUP0) begin : g_setup0
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::SETUP0;
            end else if (g == mbcm_pkg::W_SETUP1) begin : g_setup1
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::SETUP1;
            end else if (g == mbcm_pkg::W_SETUP2) begin : g_setup2
                assign word_bad[g] = state_reg.frame[g] != mbcm_pkg::SETUP2;
            end else begin : g_free
                assign word_bad[g] = 1'b0;
            end
        end
    endgenerate

    logic [31:0] pw_given;
    logic pw_ok;
    logic code_ok;
    logic args_ok;
    logic setup_ok;
    logic [7:0] check_err;

    always_comb begin
        pw_given = {state_reg.frame[mbcm_pkg::W_PW_HI], state_reg.frame[mbcm_pkg::W_PW_LO]};
        pw_ok = (pw_given == admin_password) || (pw_given == operator_password);
        code_ok = state_reg.frame[mbcm_pkg::W_CODE] == mbcm_pkg::CMD_RESET_MINMAX;
        setup_ok = !word_bad[mbcm_pkg::W_SETUP0]
            && !word_bad[mbcm_pkg::W_SETUP1]
            && !word_bad[mbcm_pkg::W_SETUP2];
        args_ok = !word_bad[mbcm_pkg::W_LEN]
            && !word_bad[mbcm_pkg::W_DEST]
            && !word_bad[mbcm_pkg::W_PWFLAG]
            && !(|word_bad[mbcm_pkg::W_UNUSED_HI:mbcm_pkg::W_UNUSED_LO])
            && setup_ok;
        // unsupported code wins over argument faults, which win over password
        if (!code_ok) begin
            check_err = mbcm_pkg::ERR_UNSUPPORTED;
        end else if (!args_ok) begin
            check_err = mbcm_pkg::ERR_ARG;
        end else if (!pw_ok) begin
            check_err = mbcm_pkg::ERR_PASSWORD;
        end else begin
            check_err = mbcm_pkg::ERR_NONE;
        end
    end

    // code of a frame that completes while busy; the completing write may itself be word0
    logic word0_write;
    logic [15:0] code_seen;

    always_comb begin
        word0_write = wr_req.valid
            && in_frame(wr_req.addr)
            && (frame_index(wr_req.addr) == 5'(mbcm_pkg::W_CODE));
        if (word0_write) begin
            code_seen = wr_req.data;
        end else begin
            code_seen = state_reg.refused_code;
        end
    end

    logic [4:0] widx;
    logic [mbcm_pkg::FRAME_WORDS-1:0] written_upd;
    logic frame_done;
    logic is_busy;

    always_comb begin
        state_next = state_reg;
        state_next.clear_pulse = 1'b0;
        state_next.rd_valid = 1'b0;
        widx = frame_index(wr_req.addr);
        written_upd = state_reg.written;
        frame_done = 1'b0;
        is_busy = state_reg.fsm != mbcm_pkg::MBCM_IDLE;

        // frame capture; words may arrive in any order
        if (wr_req.valid && in_frame(wr_req.addr)) begin
            written_upd[widx] = 1'b1;
            frame_done = &written_upd;
            if (frame_done) begin
                state_next.written = '0;
            end else begin
                state_next.written = written_upd;
            end
            // a refused frame must not disturb the running command's copy
            if (!is_busy) begin
                state_next.frame[widx] = wr_req.data;
            end
        end

        case (state_reg.fsm)
            mbcm_pkg::MBCM_IDLE: begin
                if (frame_done) begin
                    state_next.fsm = mbcm_pkg::MBCM_CHECK;
                    state_next.status = mbcm_pkg::STATUS_BUSY;
                    state_next.busy = 1'b1;
                    state_next.refused = 1'b0;
                end
            end
            mbcm_pkg::MBCM_CHECK: begin
                state_next.cmd_code = state_reg.frame[mbcm_pkg::W_CODE];
                state_next.err = check_err;
                state_next.count = '0;
                state_next.fsm = mbcm_pkg::MBCM_EXEC;
                if (check_err == mbcm_pkg::ERR_NONE) begin
                    state_next.clear_pulse = state_reg.frame[mbcm_pkg::W_PARAM][mbcm_pkg::MINMAX_CLEAR_BIT];
                end
            end
            mbcm_pkg::MBCM_EXEC: begin
                state_next.count = state_reg.count + 16'h0001;
                if (state_reg.count >= EXEC_LAST) begin
                    state_next.fsm = mbcm_pkg::MBCM_IDLE;
                    state_next.busy = 1'b0;
                    state_next.refused = 1'b0;
                    // words taken while busy were never stored, so a frame straddling
                    // completion starts over instead of running with stale words
                    state_next.written = '0;
                    if (state_reg.refused || frame_done) begin
                        // the refused code differs, so the client restarts
                        if (frame_done) begin
                            state_next.handled = code_seen;
                        end else begin
                            state_next.handled = state_reg.refused_code;
                        end
                        state_next.status = {mbcm_pkg::STATUS_DONE_HI, mbcm_pkg::ERR_BUSY};
                    end else begin
                        state_next.handled = state_reg.cmd_code;
                        state_next.status = {mbcm_pkg::STATUS_DONE_HI, state_reg.err};
                    end
                    if (state_reg.err == mbcm_pkg::ERR_NONE) begin
                        state_next.data_len = mbcm_pkg::MINMAX_DATA_LEN;
                    end
                end
            end
            default: begin
                state_next.fsm = mbcm_pkg::MBCM_IDLE;
                state_next.busy = 1'b0;
            end
        endcase

        // frame completed while busy: remember it for the refusal report
        if (frame_done && is_busy) begin
            state_next.refused = 1'b1;
        end
        if (is_busy) begin
            state_next.refused_code = code_seen;
        end

        // register reads, one cycle latency; frame words are write-only
        if (rd_req.valid) begin
            state_next.rd_valid = 1'b1;
            if (rd_req.addr == mbcm_pkg::HANDLED_ADDR) begin
                state_next.rd_data = state_reg.handled;
            end else if (rd_req.addr == mbcm_pkg::STATUS_ADDR) begin
                state_next.rd_data = state_reg.status;
            end else if (rd_req.addr == mbcm_pkg::DATA_LEN_ADDR) begin
                state_next.rd_data = state_reg.data_len;
            end else if (in_frame(rd_req.addr)) begin
                state_next.rd_data = 16'h0000;
            end else begin
                state_next.rd_data = 16'h0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg.fsm <= mbcm_pkg::MBCM_IDLE;
            state_reg.frame <= '0;
            state_reg.written <= '0;
            state_reg.cmd_code <= mbcm_pkg::RST_CODE;
            state_reg.refused <= 1'b0;
            state_reg.refused_code <= mbcm_pkg::RST_CODE;
            state_reg.err <= mbcm_pkg::ERR_NONE;
            state_reg.count <= 16'h0000;
            state_reg.handled <= mbcm_pkg::RST_CODE;
            state_reg.status <= mbcm_pkg::RST_STATUS;
            state_reg.data_len <= mbcm_pkg::RST_DATA_LEN;
            state_reg.rd_valid <= 1'b0;
            state_reg.rd_data <= 16'h0000;
            state_reg.clear_pulse <= 1'b0;
            state_reg.busy <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_valid = state_reg.rd_valid;
    assign rd_data = state_reg.rd_data;
    assign energy_minmax_clear = state_reg.clear_pulse;
    assign busy = state_reg.busy;

endmodule : mbcm_command_mailbox

// >>> mbcm_checker.sv
// port assertions of the command mailbox
`timescale 1ns/1ps
module mbcm_checker #(
    parameter int EXEC_CYCLES = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire mbcm_pkg::mbcm_wr_t wr_req,
    input wire mbcm_pkg::mbcm_rd_t rd_req,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic energy_minmax_clear,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [15:0] busy_cnt;
    // counts busy cycles so the run length is checked at its end
    always_ff @(posedge clock) begin
        if (srst || !busy) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy_cnt + 16'h0001;
        end
    end
    a_read_answer: assert property (rd_req.valid |=> rd_valid) else $error("read not answered");
    a_no_stray: assert property (!rd_req.valid |=> !rd_valid) else $error("stray read answer");
    a_status_busy: assert property (rd_req.valid && rd_req.addr == 16'h1f55 && busy
        |=> rd_data == 16'h0003) else $error("status not in progress");
    a_frame_wo: assert property (rd_req.valid && rd_req.addr >= 16'h1f40 && rd_req.addr <= 16'h1f53
        |=> rd_data == 16'h0000) else $error("frame word readable");
    a_clear_pulse: assert property (energy_minmax_clear |=> !energy_minmax_clear) else $error("clear too long");
    a_clear_timing: assert property (energy_minmax_clear |-> busy && $past(busy) && !$past(busy, 2))
        else $error("clear at wrong moment");
    a_busy_cause: assert property ($rose(busy) |-> $past(wr_req.valid && wr_req.addr >= 16'h1f40
        && wr_req.addr <= 16'h1f53)) else $error("busy without frame write");
    a_busy_length: assert property ($fell(busy) |-> busy_cnt == 16'(EXEC_CYCLES + 1))
        else $error("wrong busy length");
endmodule : mbcm_checker
bind mbcm_command_mailbox mbcm_checker #(.EXEC_CYCLES(EXEC_CYCLES)) i_mbcm_checker (
    .clock(clock), .srst(srst), .wr_req(wr_req), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_data(rd_data), .energy_minmax_clear(energy_minmax_clear), .busy(busy));

// >>> mbcm_client.sv
// remote register client model driving the mailbox
`timescale 1ns/1ps
module mbcm_client (
    input wire logic clock,
    input wire logic [15:0] rd_data,
    output mbcm_pkg::mbcm_wr_t wr_req,
    output mbcm_pkg::mbcm_rd_t rd_req
);
    initial begin
        wr_req = '0;
        rd_req = '0;
    end
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clock);
        wr_req = '{1'b1, a, d};
        @(posedge clock);
    endtask : wr
    task frame(input logic [15:0] f [20]);
        for (int i = 0; i < 20; i++) begin
            wr(16'h1f40 + 16'(i), f[i]);
        end
        @(negedge clock);
        // released lines carry the inverse, never a stale value
        wr_req = '{1'b0, ~wr_req.addr, ~wr_req.data};
    endtask : frame
    task rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clock);
        rd_req = '{1'b1, a};
        @(posedge clock);
        @(negedge clock);
        rd_req = '{1'b0, ~a};
        d = rd_data;
    endtask : rd
endmodule : mbcm_client

// >>> mbcm_command_mailbox_tb.sv
// self-checking bench of the command mailbox
`timescale 1ns/1ps
module mbcm_command_mailbox_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic rd_valid, energy_minmax_clear, busy;
    logic [15:0] rd_data;
    mbcm_pkg::mbcm_wr_t wr_req;
    mbcm_pkg::mbcm_rd_t rd_req;
    int miscompares = 0;
    int n_compared = 0;
    int n_clr = 0;
    logic [15:0] f [20];
    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (energy_minmax_clear === 1'b1) n_clr++;
    end
    // long execution so a second frame lands while busy
    mbcm_command_mailbox #(.EXEC_CYCLES(40)) i_mbcm_command_mailbox (.clock(clock), .srst(srst),
        .wr_req(wr_req), .rd_req(rd_req), .admin_password(32'h50773537), .operator_password(32'h50773538),
        .rd_valid(rd_valid), .rd_data(rd_data), .energy_minmax_clear(energy_minmax_clear), .busy(busy));
    mbcm_client i_mbcm_client (.clock(clock), .rd_data(rd_data), .wr_req(wr_req), .rd_req(rd_req));
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task base();
        f = '{0: 16'hb688, 1: 16'h000c, 2: 16'h1401, 3: 16'h0001, 4: 16'h5077, 5: 16'h3537,
            6: 16'h0200, 17: 16'h1f53, 18: 16'h1f54, 19: 16'h1f55, default: 16'h0000};
    endtask : base
    task done(input logic [15:0] code, input logic [7:0] e, input int c, input int n0);
        logic [15:0] s;
        i_mbcm_client.rd(16'h1f55, s);
        chk(s, 16'h0003);
        for (int k = 0; k < 100 && s === 16'h0003; k++) i_mbcm_client.rd(16'h1f55, s);
        chk(s, {8'h00, e});
        i_mbcm_client.rd(16'h1f54, s);
        chk(s, code);
        i_mbcm_client.rd(16'h1f56, s);
        chk(s, 16'h0000);
        i_mbcm_client.rd(16'h1f40, s);
        chk(s, 16'h0000);
        chk(16'(n_clr - n0), 16'(c));
    endtask : done
    task run(input int i, input logic [15:0] v, input logic [7:0] e, input int c);
        int n0;
        base();
        f[i] = v;
        n0 = n_clr;
        i_mbcm_client.frame(f);
        done(f[0], e, c, n0);
    endtask : run
    task t_frames();
        run(6, 16'h0200, 8'h00, 1);
        run(6, 16'h0000, 8'h00, 0);
        run(0, 16'h0300, 8'h13, 0);
        run(1, 16'h000a, 8'h0f, 0);
        run(2, 16'h1101, 8'h0f, 0);
        run(3, 16'h0000, 8'h0f, 0);
        run(9, 16'h0001, 8'h0f, 0);
        run(17, 16'h0000, 8'h0f, 0);
        run(19, 16'h1f56, 8'h0f, 0);
        run(5, 16'h3538, 8'h00, 1);
        run(5, 16'h3539, 8'h01, 0);
        run(4, 16'h7750, 8'h01, 0);
    endtask : t_frames
    task t_refuse();
        int n0;
        base();
        n0 = n_clr;
        i_mbcm_client.frame(f);
        f[0] = 16'h0300;
        i_mbcm_client.frame(f);
        done(16'h0300, 8'h9e, 1, n0);
    endtask : t_refuse
    task t_reset();
        logic [15:0] s;
        base();
        i_mbcm_client.frame(f);
        repeat (3) @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        i_mbcm_client.rd(16'h1f55, s);
        chk(s, 16'h0000);
        i_mbcm_client.rd(16'h1f54, s);
        chk(s, 16'h0000);
        run(6, 16'h0200, 8'h00, 1);
    endtask : t_reset
    task final_report();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(negedge clock);
        srst = 1'b0;
        t_frames();
        t_refuse();
        t_reset();
        final_report();
    end
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
endmodule : mbcm_command_mailbox_tb
